// file: hw/dspg_top.sv
// Behaviour
// - deep gate bit 1 clocks its port in deep sleep; 0 leaves it unclocked
// - access to a port whose clock is off answers with a bus fault
// - reset clears all gate bits; register reads zero, all ports unclocked
// - bit n gates port n, A at bit 0 up to H at bit 7, read-write
// - bits 31:8 read zero and ignore writes; software preserves them
// - deep register applies only in deep sleep; run and sleep use own registers
// - sleep and deep registers used only while auto gate enable is set
`timescale 1ns/10ps
`include "dspg_defines.svh"
module dspg_top
	import dspg_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// power mode (0 run, 1 sleep, 2 deep sleep), same clock domain
	input  wire logic [1:0]  i_power_mode,
	// axi4-lite write address
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [11:0] i_awaddr,
	// axi4-lite write data
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	// axi4-lite write response
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic [1:0]       o_bresp,
	// axi4-lite read address
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [11:0] i_araddr,
	// axi4-lite read data
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	// port clock enables, bit 0 port a
	output logic [7:0]       o_port_clock_on
);
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic        aw_held;
		logic [11:0] aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		dspg_vec_t   run_gate;
		dspg_vec_t   sleep_gate;
		dspg_vec_t   deep_gate;
		logic        auto_clock_gate_enable;
		logic [7:0]  port_on;
	} dspg_state_t;

	dspg_state_t state_reg;
	dspg_state_t state_next;
	dspg_vec_t   sel_gate;

	dspg_gate_sel u_sel (
		.i_run_gate   (state_reg.run_gate),
		.i_sleep_gate (state_reg.sleep_gate),
		.i_deep_gate  (state_reg.deep_gate),
		.i_acg        (state_reg.auto_clock_gate_enable),
		.i_mode       (i_power_mode),
		.o_gate       (sel_gate)
	);

	// port window: 0x400 + n*0x100 for port n; reached only when clocked
	function automatic logic port_hit(input logic [11:0] a, input dspg_vec_t g,
			output logic ok);
		logic [3:0] idx;
		idx = a[11:8] - 4'h4;
		ok  = 1'b0;
		if (a >= `DSPG_PORT_BASE_OFF && idx < 4'(`DSPG_PORT_COUNT)) begin
			ok = g[idx[2:0]];
			return 1'b1;
		end
		return 1'b0;
	endfunction

	always_comb begin
		logic       hit;
		logic       ok;
		logic [31:0] wm;
		hit = 1'b0;
		ok  = 1'b0;
		wm  = 32'h00000000;
		state_next = state_reg;
		state_next.port_on = sel_gate;
		if (i_awvalid && !state_reg.aw_held) begin
			state_next.aw_held = 1'b1;
			state_next.aw_addr = i_awaddr;
		end
		if (i_wvalid && !state_reg.w_held) begin
			state_next.w_held = 1'b1;
			state_next.w_data = i_wdata;
			state_next.w_strb = i_wstrb;
		end
		if (state_reg.bvalid && i_bready) begin
			state_next.bvalid = 1'b0;
		end
		if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
			state_next.aw_held = 1'b0;
			state_next.w_held  = 1'b0;
			state_next.bvalid  = 1'b1;
			state_next.bresp   = RESP_OKAY;
			for (int b = 0; b < 4; b++) begin
				wm[b*8 +: 8] = {8{state_reg.w_strb[b]}};
			end
			wm = wm & state_reg.w_data;
			hit = port_hit(state_reg.aw_addr, sel_gate, ok);
			unique case (state_reg.aw_addr)
			`DSPG_RUN_GATE_OFF: begin
				if (state_reg.w_strb[0]) state_next.run_gate = wm[7:0];
			end
			`DSPG_SLEEP_GATE_OFF: begin
				if (state_reg.w_strb[0]) state_next.sleep_gate = wm[7:0];
			end
			`DSPG_DEEP_GATE_OFF: begin
				// upper bits dropped: reserved, read only
				if (state_reg.w_strb[0]) state_next.deep_gate = wm[7:0];
			end
			`DSPG_RUN_CFG_OFF: begin
				if (state_reg.w_strb[1]) state_next.auto_clock_gate_enable = wm[`DSPG_ACG_BIT];
			end
			default: begin
				if (!(hit && ok)) state_next.bresp = RESP_SLVERR;
			end
			endcase
		end
		if (state_reg.rvalid && i_rready) begin
			state_next.rvalid = 1'b0;
		end
		if (i_arvalid && !state_reg.rvalid) begin
			state_next.rvalid = 1'b1;
			state_next.rresp  = RESP_OKAY;
			state_next.rdata  = 32'h00000000;
			hit = port_hit(i_araddr, sel_gate, ok);
			unique case (i_araddr)
			`DSPG_RUN_GATE_OFF:   state_next.rdata[7:0] = state_reg.run_gate;
			`DSPG_SLEEP_GATE_OFF: state_next.rdata[7:0] = state_reg.sleep_gate;
			`DSPG_DEEP_GATE_OFF:  state_next.rdata[7:0] = state_reg.deep_gate;
			`DSPG_RUN_CFG_OFF:    state_next.rdata[`DSPG_ACG_BIT] = state_reg.auto_clock_gate_enable;
			`DSPG_MODE_OFF:       state_next.rdata[1:0] = i_power_mode;
			default: begin
				if (!(hit && ok)) state_next.rresp = RESP_SLVERR;
			end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_awready       = !state_reg.aw_held;
	assign o_wready        = !state_reg.w_held;
	assign o_bvalid        = state_reg.bvalid;
	assign o_bresp         = state_reg.bresp;
	assign o_arready       = !state_reg.rvalid;
	assign o_rvalid        = state_reg.rvalid;
	assign o_rdata         = state_reg.rdata;
	assign o_rresp         = state_reg.rresp;
	assign o_port_clock_on = state_reg.port_on;

	sequence s_deep_write;
		state_reg.aw_held && state_reg.w_held && !state_reg.bvalid
			&& state_reg.aw_addr == `DSPG_DEEP_GATE_OFF && state_reg.w_strb[0];
	endsequence

	chk_deep_write_store: assert property (@(posedge i_clk) disable iff (i_rst)
		s_deep_write |=> state_reg.deep_gate == $past(state_reg.w_data[7:0] & 8'hFF))
		else $error("deep gate write not stored");
	chk_deep_read_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		i_arvalid && o_arready && i_araddr == `DSPG_DEEP_GATE_OFF
			|=> o_rvalid && o_rdata[31:8] == 24'h000000 && o_rdata[7:0] == $past(state_reg.deep_gate))
		else $error("deep gate read wrong");
	chk_deep_sel: assert property (@(posedge i_clk) disable iff (i_rst)
		state_reg.auto_clock_gate_enable && i_power_mode == 2'(DSPG_MODE_DEEP) |=> o_port_clock_on == $past(state_reg.deep_gate))
		else $error("deep gate not applied in deep sleep");
	chk_run_sel: assert property (@(posedge i_clk) disable iff (i_rst)
		i_power_mode == 2'(DSPG_MODE_RUN) |=> o_port_clock_on == $past(state_reg.run_gate))
		else $error("run gate not applied");
	chk_no_acg: assert property (@(posedge i_clk) disable iff (i_rst)
		!state_reg.auto_clock_gate_enable |=> o_port_clock_on == $past(state_reg.run_gate))
		else $error("sleep gating used without auto gate");
	chk_off_fault: assert property (@(posedge i_clk) disable iff (i_rst)
		i_arvalid && o_arready && i_araddr >= `DSPG_PORT_BASE_OFF && i_araddr < 12'hC00
			&& !sel_gate[3'(i_araddr[11:8] - 4'h4)] |=> o_rresp == RESP_SLVERR)
		else $error("gated port access not faulted");
	chk_port_on: assert property (@(posedge i_clk) disable iff (i_rst)
		state_reg.auto_clock_gate_enable && i_power_mode == 2'(DSPG_MODE_DEEP) && state_reg.deep_gate[0]
			|=> o_port_clock_on[0])
		else $error("port a not clocked");
	chk_reset_zero: assert property (@(posedge i_clk)
		$fell(i_rst) |-> state_reg.deep_gate == 8'h00 && o_port_clock_on == 8'h00)
		else $error("reset value not zero");
	chk_bresp_follows: assert property (@(posedge i_clk) disable iff (i_rst)
		s_deep_write |=> o_bvalid && o_bresp == RESP_OKAY)
		else $error("write response missing");
endmodule

// file: hw/dspg_defines.svh
`ifndef DSPG_DEFINES_SVH
`define DSPG_DEFINES_SVH

`define DSPG_RUN_GATE_OFF       12'h108
`define DSPG_SLEEP_GATE_OFF     12'h118
`define DSPG_DEEP_GATE_OFF      12'h128
`define DSPG_RUN_CFG_OFF        12'h060
`define DSPG_MODE_OFF           12'h130
`define DSPG_GATE_RESET         32'h00000000
`define DSPG_RUN_CFG_RESET      32'h00000000
`define DSPG_ACG_BIT            11
`define DSPG_PORT_COUNT         8
`define DSPG_PORT_BASE_OFF      12'h400
`define DSPG_PORT_SEL_LSB       8

`endif

// file: hw/dspg_pkg.sv
package dspg_pkg;
	typedef enum logic [1:0] {
		DSPG_MODE_RUN,
		DSPG_MODE_SLEEP,
		DSPG_MODE_DEEP
	} dspg_mode_t;

	typedef logic [7:0] dspg_vec_t;
endpackage

// file: hw/dspg_gate_sel.sv
`timescale 1ns/10ps
module dspg_gate_sel
	import dspg_pkg::*;
(
	// gating sources
	input  wire dspg_vec_t  i_run_gate,
	input  wire dspg_vec_t  i_sleep_gate,
	input  wire dspg_vec_t  i_deep_gate,
	// control
	input  wire logic       i_acg,
	input  wire logic [1:0] i_mode,
	// result
	output dspg_vec_t       o_gate
);
	// without auto gating the run vector applies in every mode
	always_comb begin
		o_gate = i_run_gate;
		if (i_acg && i_mode == 2'(DSPG_MODE_SLEEP)) begin
			o_gate = i_sleep_gate;
		end else if (i_acg && i_mode == 2'(DSPG_MODE_DEEP)) begin
			o_gate = i_deep_gate;
		end
	end
endmodule

// file: dv/testbench.sv
`timescale 1ns/10ps
module testbench
	import dspg_pkg::*;
;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [1:0]  mode  = 2'h0;
	logic        awv   = 1'b0;
	logic        wv    = 1'b0;
	logic        br    = 1'b0;
	logic        arv   = 1'b0;
	logic        rr    = 1'b0;
	logic [11:0] awa   = 12'h000;
	logic [11:0] ara   = 12'h000;
	logic [31:0] wd    = 32'h00000000;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0]  o_bresp, o_rresp;
	logic [31:0] o_rdata, d, rn, sl, dp, seed;
	logic [7:0]  o_port_clock_on;
	logic [1:0]  r;
	logic [2:0]  p;
	logic [7:0]  g;
	int          n_errors = 0;
	int          total_checks = 0;

	dspg_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_power_mode(mode),
		.i_awvalid(awv), .o_awready(o_awready), .i_awaddr(awa),
		.i_wvalid(wv), .o_wready(o_wready), .i_wdata(wd), .i_wstrb(4'hF),
		.o_bvalid(o_bvalid), .i_bready(br), .o_bresp(o_bresp),
		.i_arvalid(arv), .o_arready(o_arready), .i_araddr(ara),
		.o_rvalid(o_rvalid), .i_rready(rr), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.o_port_clock_on(o_port_clock_on));

	always #2.5 i_clk = ~i_clk;

	function automatic logic [31:0] nx(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// without auto gating the run vector holds in every mode
	function automatic logic [7:0] sel(logic [1:0] m, logic g, logic [7:0] a, b, c);
		if (g && m == 2'h1) return b;
		if (g && m == 2'h2) return c;
		return a;
	endfunction

	task automatic end_of_test;
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// ready is looked at on the falling edge so the release never races the design
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] q);
		logic ta, tw, tb;
		int   k;
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= v;
		br <= 1'b1;
		tb = 1'b0;
		for (k = 0; k < 40 && !tb; k++) begin
			@(negedge i_clk);
			ta = awv && o_awready;
			tw = wv && o_wready;
			tb = (o_bvalid === 1'b1);
			q = o_bresp;
			@(posedge i_clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (tb) br <= 1'b0;
		end
		// one idle edge so the next call never reassigns bready in the same step
		@(posedge i_clk);
		if (!tb) begin
			n_errors++;
			end_of_test;
		end
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] q);
		logic ta, tb;
		int   k;
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		tb = 1'b0;
		for (k = 0; k < 40 && !tb; k++) begin
			@(negedge i_clk);
			ta = arv && o_arready;
			tb = (o_rvalid === 1'b1);
			v = o_rdata;
			q = o_rresp;
			@(posedge i_clk);
			if (ta) arv <= 1'b0;
			if (tb) rr <= 1'b0;
		end
		@(posedge i_clk);
		if (!tb) begin
			n_errors++;
			end_of_test;
		end
	endtask

	initial begin
		seed = 32'h0000C294;
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		@(negedge i_clk);
		chk({24'h000000, o_port_clock_on}, 32'h00000000);
		@(posedge i_clk);
		rd(12'h128, d, r);
		chk(d, 32'h00000000);
		rd(12'h004, d, r);
		chk({30'h0, r}, 32'h00000002);
		// first two passes are the all-clear and all-set corners
		for (int k = 0; k < 12; k++) begin
			seed = nx(nx(nx(seed)));
			rn = (k == 0) ? 32'h00000000 : (k == 1) ? 32'hFFFFFFFF : seed;
			sl = (k < 2) ? rn : {seed[15:0], seed[31:16]};
			dp = (k < 2) ? rn : ~seed;
			p = k[2:0];
			wr(12'h108, rn, r);
			wr(12'h118, sl, r);
			wr(12'h128, dp, r);
			chk({30'h0, r}, 32'h00000000);
			wr(12'h060, {20'h00000, k[1], 11'h000}, r);
			rd(12'h128, d, r);
			chk(d, {24'h000000, dp[7:0]});
			for (int m = 0; m < 4; m++) begin
				mode <= m[1:0];
				g = sel(m[1:0], k[1], rn[7:0], sl[7:0], dp[7:0]);
				repeat (2) @(posedge i_clk);
				@(negedge i_clk);
				chk({24'h000000, o_port_clock_on}, {24'h000000, g});
				@(posedge i_clk);
				rd(12'h400 + {1'b0, p, 8'h00}, d, r);
				chk({30'h0, r}, g[p] ? 32'h00000000 : 32'h00000002);
				wr(12'h400 + {1'b0, p, 8'h00}, seed, r);
				chk({30'h0, r}, g[p] ? 32'h00000000 : 32'h00000002);
				rd(12'h130, d, r);
				chk(d, {30'h0, m[1:0]});
			end
		end
		// reset again with gate bits set, to see them really cleared
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(negedge i_clk);
		chk({24'h000000, o_port_clock_on}, 32'h00000000);
		@(posedge i_clk);
		rd(12'h128, d, r);
		chk(d, 32'h00000000);
		end_of_test;
	end
endmodule
